// [pkg/mpc_consts.vh]
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH
// ==========================================================
// Mode encodings (mode switch)
`define MPC_MODE_W          2
`define MPC_MODE_POOL       2'h0
`define MPC_MODE_HOT        2'h1
`define MPC_MODE_POOL_DTR   2'h2
`define MPC_MODE_HOT_DTR    2'h3
// ==========================================================
// Timing
`define MPC_CLK_HZ          100000000
`define MPC_TICK_HZ         1000
`define MPC_TICK_DIV        (`MPC_CLK_HZ / `MPC_TICK_HZ)
`define MPC_DROP_MS         16'h00C8
`define MPC_GUARD_MS        16'h07D0
`define MPC_DCD_WAIT_MS     16'h88B8
`define MPC_TMR_W           16
`define MPC_DIV_W           17
// ==========================================================
// Speed switches
`define MPC_RATE_W          3
`define MPC_RATE_RST        3'h0
`endif

// [hw/mpc_timer.v]
`timescale 1ns/1ns
`include "mpc_consts.vh"
// ==========================================================
// Millisecond interval timer, restartable
module mpc_timer #(
  parameter TICK_DIV = `MPC_TICK_DIV
) (
  // Clock and reset
  input  wire                   clock_i,
  input  wire                   resetn_i,
  input  wire                   ce_i,
  // Control
  input  wire                   restart_i,
  input  wire [`MPC_TMR_W-1:0]  limit_i,
  // Status
  output reg                    done_o
);
  reg [`MPC_DIV_W-1:0] div_ff;
  reg [`MPC_TMR_W-1:0] cnt_ff;
  wire                 tick = (div_ff == TICK_DIV - 1);

  always @(posedge clock_i) begin
    if (!resetn_i) begin
      div_ff <= {`MPC_DIV_W{1'b0}};
      cnt_ff <= {`MPC_TMR_W{1'b0}};
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (restart_i) begin
        div_ff <= {`MPC_DIV_W{1'b0}};
        cnt_ff <= {`MPC_TMR_W{1'b0}};
        done_o <= 1'b0;
      end else begin
        div_ff <= tick ? {`MPC_DIV_W{1'b0}} : div_ff + 1'b1;
        if (tick && !done_o) begin
          cnt_ff <= cnt_ff + 1'b1;
          done_o <= (cnt_ff + 1'b1 >= limit_i);
        end
      end
    end
  end
endmodule // mpc_timer

// [hw/mpc_ctrl.v]
`timescale 1ns/1ns
`include "mpc_consts.vh"
module mpc_ctrl #(
  parameter TICK_DIV = `MPC_TICK_DIV
) (
  // Clock and reset
  input  wire                     clock_i,
  input  wire                     resetn_i,
  input  wire                     ce_i,
  // Configuration switches
  input  wire [`MPC_MODE_W-1:0]   mode_i,
  input  wire [`MPC_RATE_W-1:0]   rate_sw_i,
  // Modem control leads
  input  wire                     dsr_i,
  input  wire                     dcd_i,
  input  wire                     ri_i,
  output reg                      dtr_o,
  // Call processing side
  input  wire                     out_req_i,
  input  wire                     release_i,
  input  wire                     cr_seen_i,
  output reg                      busy_o,
  output reg                      out_ack_o,
  output reg                      link_open_o,
  output reg                      hotline_req_o,
  output reg                      autobaud_o,
  output reg                      fixed_rate_o,
  output reg  [`MPC_RATE_W-1:0]   rate_o,
  output reg                      released_o
);
  // ==========================================================
  // States
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_OUT   = 7'h02;
  localparam [6:0] ST_RING  = 7'h04;
  localparam [6:0] ST_BAUD  = 7'h08;
  localparam [6:0] ST_CONN  = 7'h10;
  localparam [6:0] ST_DROP  = 7'h20;
  localparam [6:0] ST_GUARD = 7'h40;

  // ==========================================================
  // Pin synchronisers
  reg [1:0] dsr_sync_ff;
  reg [1:0] dcd_sync_ff;
  reg [1:0] ri_sync_ff;
  wire      dsr = dsr_sync_ff[1];
  wire      dcd = dcd_sync_ff[1];
  wire      ri  = ri_sync_ff[1];

  always @(posedge clock_i) begin
    if (!resetn_i) begin
      dsr_sync_ff <= 2'h0;
      dcd_sync_ff <= 2'h0;
      ri_sync_ff  <= 2'h0;
    end else if (ce_i) begin
      dsr_sync_ff <= {dsr_sync_ff[0], dsr_i};
      dcd_sync_ff <= {dcd_sync_ff[0], dcd_i};
      ri_sync_ff  <= {ri_sync_ff[0], ri_i};
    end
  end

  // ==========================================================
  // Mode decode
  function dtr_held;
    input [`MPC_MODE_W-1:0] m;
    begin
      dtr_held = (m == `MPC_MODE_POOL_DTR) || (m == `MPC_MODE_HOT_DTR);
    end
  endfunction

  function is_hot;
    input [`MPC_MODE_W-1:0] m;
    begin
      is_hot = (m == `MPC_MODE_HOT) || (m == `MPC_MODE_HOT_DTR);
    end
  endfunction

  // ==========================================================
  // State and timer
  reg [6:0]            state_ff;
  reg [6:0]            nxt_state;
  reg                  hot_call_ff;
  reg                  nxt_hot_call;
  reg [`MPC_TMR_W-1:0] limit;
  wire                 tmr_done;
  wire                 entering = (nxt_state != state_ff);

  always @* begin
    case (nxt_state)
      ST_DROP:  limit = `MPC_DROP_MS;
      ST_GUARD: limit = `MPC_GUARD_MS;
      default:  limit = `MPC_DCD_WAIT_MS;
    endcase
  end

  // Timer restarts whenever a state is entered
  mpc_timer #(
    .TICK_DIV  (TICK_DIV)
  ) u_timer (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .restart_i (entering),
    .limit_i   (limit),
    .done_o    (tmr_done)
  );

  // ==========================================================
  // Call sequencing
  always @* begin
    nxt_state    = state_ff;
    nxt_hot_call = hot_call_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_hot_call = 1'b0;
        if (ri) begin
          nxt_state    = ST_RING;
          nxt_hot_call = is_hot(mode_i);
        end else if (out_req_i && !is_hot(mode_i)) begin
          nxt_state = ST_OUT;
        end
      end
      ST_OUT: begin
        // Modem gets the same 35 s to bring up carrier
        if (release_i || tmr_done)
          nxt_state = ST_DROP;
        else if (dsr && dcd)
          nxt_state = ST_CONN;
      end
      ST_RING: begin
        if (release_i || tmr_done)
          nxt_state = ST_DROP;
        else if (dcd)
          nxt_state = hot_call_ff ? ST_CONN : ST_BAUD;
      end
      ST_BAUD: begin
        if (release_i || !dcd || !dsr)
          nxt_state = ST_DROP;
        else if (cr_seen_i)
          nxt_state = ST_CONN;
      end
      ST_CONN: begin
        if (release_i || !dcd || !dsr)
          nxt_state = ST_DROP;
      end
      ST_DROP: begin
        // Drop lasts 0.2 s in every mode so modem sees DTR fall
        if (tmr_done)
          nxt_state = (mode_i == `MPC_MODE_POOL_DTR) ? ST_GUARD : ST_IDLE;
      end
      ST_GUARD: begin
        // RI and DCD not looked at here: modem echoes them back
        if (tmr_done)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Registers and outputs
  wire active  = (nxt_state == ST_OUT) || (nxt_state == ST_RING) ||
                 (nxt_state == ST_BAUD) || (nxt_state == ST_CONN);
  wire nxt_dtr = (nxt_state == ST_DROP) ? 1'b0 :
                 (dtr_held(mode_i) ? 1'b1 : active);

  always @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff      <= ST_IDLE;
      hot_call_ff   <= 1'b0;
      dtr_o         <= 1'b0;
      busy_o        <= 1'b0;
      out_ack_o     <= 1'b0;
      link_open_o   <= 1'b0;
      hotline_req_o <= 1'b0;
      autobaud_o    <= 1'b0;
      fixed_rate_o  <= 1'b0;
      rate_o        <= `MPC_RATE_RST;
      released_o    <= 1'b0;
    end else if (ce_i) begin
      state_ff      <= nxt_state;
      hot_call_ff   <= nxt_hot_call;
      dtr_o         <= nxt_dtr;
      busy_o        <= active;
      out_ack_o     <= (state_ff == ST_IDLE) && (nxt_state == ST_OUT);
      link_open_o   <= (nxt_state == ST_OUT) || (nxt_state == ST_CONN);
      hotline_req_o <= (state_ff == ST_RING) && (nxt_state == ST_CONN);
      autobaud_o    <= (nxt_state == ST_BAUD);
      fixed_rate_o  <= nxt_hot_call && active;
      if ((state_ff == ST_IDLE) && (nxt_state == ST_RING))
        rate_o <= rate_sw_i;
      released_o    <= (state_ff != ST_DROP) && (nxt_state == ST_DROP);
    end
  end
endmodule // mpc_ctrl

// [verification/mpc_modem_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Modem on the control leads
module mpc_modem_model #(
  parameter RING_CYC = 20
) (
  // Line side, commanded by the bench
  input  wire clock_i,
  input  wire ring_i,
  input  wire ans_i,
  // Control leads
  input  wire dtr_i,
  output wire dsr_o,
  output wire dcd_o,
  output wire ri_o
);
  logic       car_ff = 1'h0;
  logic [7:0] cfg_ff = 8'h0;
  int         rcnt_ff = 0;
  always @(posedge clock_i) begin
    rcnt_ff <= (ring_i && dtr_i) ? rcnt_ff + 1 : 0;
    // No answer before a whole ring, never without DTR
    car_ff <= dtr_i && ans_i && (car_ff || !ring_i || rcnt_ff >= RING_CYC);
    // Settings drift in use, back to default on DTR drop
    cfg_ff <= dtr_i ? cfg_ff + 8'h1 : 8'h0;
  end
  assign ri_o  = ring_i && !car_ff;
  assign dcd_o = car_ff;
  assign dsr_o = dtr_i;
endmodule // mpc_modem_model

// [verification/mpc_ctrl_monitor.sv]
`timescale 1ns/1ns
`include "mpc_consts.vh"
// ==========================================================
// Control-lead checker
module mpc_ctrl_monitor #(
  parameter TICK_DIV = 1
) (
  input wire                   clock_i, resetn_i, dsr_i, dcd_i, cr_seen_i,
  input wire [`MPC_MODE_W-1:0] mode_i,
  input wire                   dtr_o, busy_o, out_ack_o, link_open_o,
  input wire                   hotline_req_o, autobaud_o, released_o
);
  localparam int DLO = 200 * TICK_DIV - 2;
  localparam int DHI = 202 * TICK_DIV + 8;
  localparam int GRD = 2200 * TICK_DIV - 4;
  localparam int TMO = 35002 * TICK_DIV + 8;
  // Cycles since release; arm_ff keeps out the time before the first drop
  int   rel_ff;
  int   wt_ff;
  logic arm_ff;
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      rel_ff <= 0;
      wt_ff <= 0;
      arm_ff <= 1'h0;
    end else begin
      arm_ff <= arm_ff | released_o;
      rel_ff <= released_o ? 1 : rel_ff + int'(rel_ff < 2 * GRD);
      wt_ff <= (busy_o && !link_open_o && !autobaud_o) ? wt_ff + 1 : 0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence conn_s;
    (link_open_o && dsr_i && dcd_i) [*6];
  endsequence
  sequence ack_s;
    out_ack_o && dtr_o && busy_o ##1 !out_ack_o;
  endsequence
  chk_call_dtr_on: assert property (busy_o |-> dtr_o)
    else $error("dtr low during call");
  chk_idle_dtr_off: assert property (!mode_i[1] && !busy_o |-> !dtr_o)
    else $error("dtr high while idle");
  chk_drop_short: assert property (arm_ff && mode_i[1] && !dtr_o |-> rel_ff <= DHI)
    else $error("dtr drop too long");
  chk_drop_long: assert property ($rose(dtr_o) && arm_ff |-> rel_ff >= DLO)
    else $error("dtr drop too short");
  chk_ack_pulse: assert property (out_ack_o |-> !mode_i[0] ##0 ack_s)
    else $error("bad outbound answer");
  chk_lead_loss: assert property (conn_s ##1 (link_open_o && !(dsr_i && dcd_i))
    |-> ##[1:5] released_o)
    else $error("lead loss not released");
  chk_carrier_wait: assert property (wt_ff <= TMO)
    else $error("carrier wait overrun");
  chk_cr_ends_baud: assert property (autobaud_o && cr_seen_i |=> !autobaud_o)
    else $error("autobaud not ended");
  chk_hot_mode: assert property (hotline_req_o |-> mode_i[0] ##1 !hotline_req_o)
    else $error("bad hotline request");
  chk_guard_quiet: assert property (arm_ff && mode_i == `MPC_MODE_POOL_DTR && rel_ff < GRD
    |-> !busy_o)
    else $error("call during guard");
endmodule // mpc_ctrl_monitor

// [verification/tb_mpc_ctrl.sv]
`timescale 1ns/1ns
`include "mpc_consts.vh"
// ==========================================================
// Bench
module tb_mpc_ctrl;
  localparam int T = 1;
  logic clock_i = 1'h0, resetn_i = 1'h0, ring = 1'h0, ans = 1'h0;
  logic oreq = 1'h0, rls = 1'h0, cr = 1'h0;
  logic [`MPC_MODE_W-1:0] mode_i = 2'h0;
  logic [`MPC_RATE_W-1:0] rate_sw_i = 3'h0;
  wire [`MPC_RATE_W-1:0] rate;
  wire dsr, dcd, ri, dtr, busy, ack, lnk, hot, ab, fix, rel;
  int failures = 0, check_count = 0, n;
  always #5 clock_i = ~clock_i;
  mpc_ctrl #(.TICK_DIV(T)) dut (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'h1),
    .mode_i(mode_i), .rate_sw_i(rate_sw_i), .dsr_i(dsr), .dcd_i(dcd), .ri_i(ri), .dtr_o(dtr),
    .out_req_i(oreq), .release_i(rls), .cr_seen_i(cr), .busy_o(busy), .out_ack_o(ack),
    .link_open_o(lnk), .hotline_req_o(hot), .autobaud_o(ab), .fixed_rate_o(fix),
    .rate_o(rate), .released_o(rel));
  mpc_modem_model modem (.clock_i(clock_i), .ring_i(ring), .ans_i(ans), .dtr_i(dtr),
    .dsr_o(dsr), .dcd_o(dcd), .ri_o(ri));
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  // Bounded wait: 0 busy, 1 released, 2 autobaud or hotline
  task wt(input int w, input int lim);
    n = 0;
    #1;
    while (!(w == 0 ? busy : w == 1 ? rel : ab | hot) !== 1'h0) begin
      @(posedge clock_i);
      #1;
      n++;
      if (n > lim) begin
        chk(4'h0, 4'h1);
        tally_and_finish;
      end
    end
  endtask
  task rst(input logic [1:0] m);
    @(posedge clock_i);
    resetn_i <= 1'h0;
    mode_i <= m;
    rate_sw_i <= 3'($urandom);
    ring <= 1'h0;
    ans <= 1'h0;
    cyc(10);
    resetn_i <= 1'h1;
    cyc(2);
    #1 chk(dtr, m[1]);
  endtask
  initial begin
    void'($urandom(83344));
    for (int m = 0; m < 4; m++) begin
      rst(m[1:0]);
      @(posedge clock_i) ring <= 1'h1;
      ans <= 1'h1;
      wt(0, 50);
      chk(dtr, 1'h1);
      wt(2, 200);
      if (m[0]) begin
        chk(hot, 1'h1);
        cyc(2);
        #1 chk({fix, rate}, {1'h1, rate_sw_i});
      end else begin
        chk({ab, fix}, 2'h2);
        @(posedge clock_i) cr <= 1'h1;
        @(posedge clock_i) cr <= 1'h0;
        cyc(1);
        #1 chk({ab, lnk}, 2'h1);
      end
      cyc(10);
      @(posedge clock_i) ring <= 1'h0;
      ans <= 1'h0;
      wt(1, 20);
      chk({busy, dtr}, 2'h0);
      if (m == 2) begin
        @(posedge clock_i) ring <= 1'h1;
        wt(0, 3000 * T);
        chk(n > 2150 * T, 1'h1);
      end else begin
        cyc(150 * T);
        #1 chk(dtr, 1'h0);
        cyc(100 * T);
        #1 chk(dtr, m[1]);
      end
      $display("inbound mode %0d done", m);
      rst(m[1:0]);
      @(posedge clock_i) oreq <= 1'h1;
      @(posedge clock_i) oreq <= 1'h0;
      #1 chk({ack, dtr, lnk}, {~m[0], ~m[0] | m[1], ~m[0]});
      if (!m[0]) begin
        @(posedge clock_i) ans <= 1'h1;
        cyc(8);
        @(posedge clock_i) rls <= 1'h1;
        @(posedge clock_i) rls <= 1'h0;
        wt(1, 10);
        chk({lnk, dtr}, 2'h0);
        cyc(1);
        #1 chk(modem.cfg_ff[3:0], 4'h0);
      end
      $display("outbound mode %0d done", m);
    end
    // Modem never raises carrier
    rst(2'h0);
    @(posedge clock_i) ring <= 1'h1;
    wt(0, 50);
    @(posedge clock_i) ring <= 1'h0;
    wt(1, 35100 * T);
    chk(n > 34990 * T, 1'h1);
    $display("carrier timeout done");
    tally_and_finish;
  end
endmodule // tb_mpc_ctrl
bind mpc_ctrl mpc_ctrl_monitor #(.TICK_DIV(TICK_DIV)) mon (.clock_i(clock_i),
  .resetn_i(resetn_i), .dsr_i(dsr_i), .dcd_i(dcd_i), .cr_seen_i(cr_seen_i), .mode_i(mode_i),
  .dtr_o(dtr_o), .busy_o(busy_o), .out_ack_o(out_ack_o), .link_open_o(link_open_o),
  .hotline_req_o(hotline_req_o), .autobaud_o(autobaud_o), .released_o(released_o));
